// ---- shared/strap_pkg.sv ----
`default_nettype none

package strap_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] STATUS_OFFS   = 8'h00;
    localparam logic [7:0] IRQ_CFG_OFFS  = 8'h04;
    localparam logic [7:0] BOOT_CTL_OFFS = 8'h08;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ST_BOOT_BIT  = 0;
    localparam int ST_IRQ_BIT   = 1;
    localparam int ST_TMA_BIT   = 2;
    localparam int ST_TMB_BIT   = 3;
    localparam int ST_DONE_BIT  = 4;
    localparam int ST_IDLE_BIT  = 5;
    localparam int ST_RUN_BIT   = 6;
    localparam int ST_FAULT_BIT = 7;
    localparam int IRQ_EN_LSB   = 0;
    localparam int IRQ_EDGE_LSB = 4;
    localparam int BOOT_GO_BIT  = 0;

    // ****************************************
    // values
    // ****************************************
    localparam int          IRQ_COUNT     = 4;
    localparam logic        STRAP_DEFAULT = 1'b0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

    typedef enum logic [3:0] {
        BOOT_WAIT = 4'h1,
        BOOT_PROM = 4'h2,
        BOOT_IDLE = 4'h4,
        BOOT_RUN  = 4'h8
    } boot_state_t;

endpackage : strap_pkg

`default_nettype wire

// ---- src/reset_strap_mode_capture.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module reset_strap_mode_capture #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // shared strap pins
    input  wire logic              boot_select_pin,
    input  wire logic              bus_master_pin,
    input  wire logic              link2_direction_pin,
    input  wire logic              timer0_expired_pin,
    // loader
    input  wire logic              ext_load_done,
    // mode outputs
    output logic                   strap_role,
    output logic                   boot_prom_start,
    output logic                   core_idle,
    output logic                   core_run,
    output logic [3:0]             external_interrupt_en,
    output logic [3:0]             external_interrupt_edge,
    output logic                   test_strap_fault,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ****************************************
    // strap capture
    // ****************************************
    // capture flops carry no reset: an async reset may only load constants,
    // so they track the pins each edge until the first edge after release
    logic cap_boot_q;
    logic cap_irq_q;
    logic cap_tma_q;
    logic cap_tmb_q;
    logic done_q;

    always_ff @(posedge core_clk) begin
        if (!done_q) begin
            cap_boot_q <= boot_select_pin;
            cap_irq_q  <= bus_master_pin;
            cap_tma_q  <= link2_direction_pin;
            cap_tmb_q  <= timer0_expired_pin;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b1;
        end
    end

    assign strap_role = !done_q;

    wire test_bad = (cap_tma_q != strap_pkg::STRAP_DEFAULT) ||
                    (cap_tmb_q != strap_pkg::STRAP_DEFAULT);
    assign test_strap_fault = done_q && test_bad;

    // ****************************************
    // boot sequencing
    // ****************************************
    strap_pkg::boot_state_t state_q;
    strap_pkg::boot_state_t state_d;
    logic                   sw_go;

    always_comb begin
        case (state_q)
            strap_pkg::BOOT_WAIT: begin
                if (!done_q) begin
                    state_d = strap_pkg::BOOT_WAIT;
                end else if (cap_boot_q == strap_pkg::STRAP_DEFAULT) begin
                    state_d = strap_pkg::BOOT_PROM;
                end else begin
                    state_d = strap_pkg::BOOT_IDLE;
                end
            end
            strap_pkg::BOOT_PROM: begin
                state_d = strap_pkg::BOOT_RUN;
            end
            strap_pkg::BOOT_IDLE: begin
                if (ext_load_done || sw_go) begin
                    state_d = strap_pkg::BOOT_RUN;
                end else begin
                    state_d = strap_pkg::BOOT_IDLE;
                end
            end
            strap_pkg::BOOT_RUN: begin
                state_d = strap_pkg::BOOT_RUN;
            end
            default: begin
                state_d = strap_pkg::BOOT_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= strap_pkg::BOOT_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    assign boot_prom_start = (state_q == strap_pkg::BOOT_PROM);
    assign core_idle       = (state_q == strap_pkg::BOOT_IDLE);
    assign core_run        = (state_q == strap_pkg::BOOT_RUN);

    // ****************************************
    // interrupt mode
    // ****************************************
    logic [3:0] irq_en_q;
    logic [3:0] irq_edge_q;
    logic       cfg_wr;
    logic [31:0] wdata_q;
    wire        mode_init = (state_q == strap_pkg::BOOT_WAIT) && done_q;

    // seed from strap, then software owns it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_q   <= 4'h0;
            irq_edge_q <= 4'h0;
        end else if (mode_init) begin
            irq_en_q   <= {strap_pkg::IRQ_COUNT{cap_irq_q}};
            irq_edge_q <= {strap_pkg::IRQ_COUNT{cap_irq_q}};
        end else if (cfg_wr) begin
            irq_en_q   <= wdata_q[strap_pkg::IRQ_EN_LSB +: 4];
            irq_edge_q <= wdata_q[strap_pkg::IRQ_EDGE_LSB +: 4];
        end
    end

    assign external_interrupt_en   = irq_en_q;
    assign external_interrupt_edge = irq_edge_q;

    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic              wlow_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    wire   aw_take       = s_axi_awvalid && s_axi_awready;
    wire   w_take        = s_axi_wvalid && s_axi_wready;
    wire   wr_fire       = aw_hold_q && w_hold_q;
    wire   wa_cfg        = (awaddr_q[7:0] == strap_pkg::IRQ_CFG_OFFS);
    wire   wa_boot       = (awaddr_q[7:0] == strap_pkg::BOOT_CTL_OFFS);
    wire   wa_ok         = wa_cfg || wa_boot;
    // byte lane 0 holds every writable field
    assign cfg_wr = wr_fire && wa_cfg && wlow_q;
    assign sw_go  = wr_fire && wa_boot && wlow_q && wdata_q[strap_pkg::BOOT_GO_BIT];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= strap_pkg::DATA_ZERO;
            wlow_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= strap_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wlow_q   <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wa_ok ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    wire   ar_take       = s_axi_arvalid && s_axi_arready;

    wire [31:0] status_word = {24'h00_0000, test_strap_fault, core_run, core_idle,
                               done_q, cap_tmb_q, cap_tma_q, cap_irq_q, cap_boot_q};
    wire [31:0] cfg_word    = {24'h00_0000, irq_edge_q, irq_en_q};
    wire        ra_st       = (s_axi_araddr[7:0] == strap_pkg::STATUS_OFFS);
    wire        ra_cfg      = (s_axi_araddr[7:0] == strap_pkg::IRQ_CFG_OFFS);
    wire        ra_boot     = (s_axi_araddr[7:0] == strap_pkg::BOOT_CTL_OFFS);
    wire [31:0] rd_mux      = ra_st  ? status_word :
                              ra_cfg ? cfg_word    : strap_pkg::DATA_ZERO;
    wire        rd_ok       = ra_st || ra_cfg || ra_boot;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= strap_pkg::DATA_ZERO;
            rresp_q  <= strap_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_release;
        !done_q ##1 done_q;
    endsequence

    chk_strap_sampled: assert property (
        seq_release |-> (cap_boot_q == $past(boot_select_pin)) &&
                        (cap_irq_q == $past(bus_master_pin)))
        else $error("strap not sampled at release");
    chk_default_zero: assert property (
        seq_release ##0 (cap_boot_q == 1'b0) |=> !core_idle)
        else $error("low strap did not give default boot");
    chk_prom_boot: assert property (
        mode_init && !cap_boot_q |=> boot_prom_start ##1 core_run)
        else $error("prom boot not started after reset");
    chk_idle_hold: assert property (
        core_idle && !ext_load_done && !sw_go |=> core_idle && !boot_prom_start)
        else $error("idle left without a loader");
    chk_irq_level: assert property (
        mode_init && !cap_irq_q |=> (external_interrupt_en == 4'h0) &&
                                     (external_interrupt_edge == 4'h0))
        else $error("irq not disabled level after reset");
    chk_irq_edge: assert property (
        mode_init && cap_irq_q |=> (external_interrupt_en == 4'hf) &&
                                    (external_interrupt_edge == 4'hf))
        else $error("irq not enabled edge after reset");
    chk_strap_frozen: assert property (
        done_q |=> $stable(cap_boot_q) && $stable(cap_irq_q) && !strap_role)
        else $error("captured strap changed after reset");
    chk_write_answer: assert property (
        wr_fire |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : reset_strap_mode_capture

`default_nettype wire

// ---- test/strap_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// board straps and post-reset pin traffic
// ****************************************
module strap_board_model (
    // clock and role
    input  wire logic       core_clk,
    input  wire logic       strap_role,
    // chosen levels: boot, irq, test a, test b
    input  wire logic [3:0] strap_cfg,
    // shared pins
    output logic            boot_select_pin,
    output logic            bus_master_pin,
    output logic            link2_direction_pin,
    output logic            timer0_expired_pin
);
    logic [3:0] pins;
    logic [3:0] traffic_q;

    // pins run normal traffic after release, so a late sample would differ
    always_ff @(posedge core_clk) begin
        traffic_q <= (strap_role !== 1'b0) ? ~strap_cfg : ~traffic_q;
    end

    // zero stands for the pad pull-down, one is a held pull-up
    assign pins                = (strap_role !== 1'b0) ? strap_cfg : traffic_q;
    assign boot_select_pin     = pins[0];
    assign bus_master_pin      = pins[1];
    assign link2_direction_pin = pins[2];
    assign timer0_expired_pin  = pins[3];
endmodule : strap_board_model

`default_nettype wire

// ---- test/reset_strap_mode_capture_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module reset_strap_mode_capture_tb;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  strap_cfg = 4'h0;
    logic        ext_load_done = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        boot_select_pin, bus_master_pin, link2_direction_pin, timer0_expired_pin;
    logic        strap_role, boot_prom_start, core_idle, core_run, test_strap_fault;
    logic [3:0]  external_interrupt_en, external_interrupt_edge;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0]  cfg_tbl [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic [7:0]  exp_st;
    logic [3:0]  c;
    int          err_count = 0;
    int          samples_checked = 0;

    always #20 core_clk = ~core_clk;

    strap_board_model board (.core_clk, .strap_role, .strap_cfg, .boot_select_pin,
        .bus_master_pin, .link2_direction_pin, .timer0_expired_pin);

    reset_strap_mode_capture dut (.core_clk, .rstn, .boot_select_pin, .bus_master_pin,
        .link2_direction_pin, .timer0_expired_pin, .ext_load_done, .strap_role,
        .boot_prom_start, .core_idle, .core_run, .external_interrupt_en,
        .external_interrupt_edge, .test_strap_fault, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ****************************************
    // checks and bus tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_t) begin
            @(negedge core_clk);
            aw_t = s_axi_awvalid && (s_axi_awready === 1'b1);
            w_t = s_axi_wvalid && (s_axi_wready === 1'b1);
            b_t = s_axi_bvalid === 1'b1;
            if (b_t) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            @(posedge core_clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) s_axi_bready <= 1'b0;
        end
    endtask : axi_write

    task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_t) begin
            @(negedge core_clk);
            ar_t = s_axi_arvalid && (s_axi_arready === 1'b1);
            r_t = s_axi_rvalid === 1'b1;
            if (r_t) chk("rdata", ed, s_axi_rdata);
            if (r_t) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            @(posedge core_clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) s_axi_rready <= 1'b0;
        end
    endtask : axi_read

    task test_done;
        $display("mismatches %0d of %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    // ****************************************
    // strap sweep
    // ****************************************
    initial begin
        for (int i = 0; i < 6; i++) begin
            c = cfg_tbl[i];
            @(posedge core_clk);
            rstn <= 1'b0;
            strap_cfg <= c;
            repeat (12) @(posedge core_clk);
            chk("strap_role", 32'h1, {31'h0, strap_role});
            rstn <= 1'b1;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            // modes follow captured straps at edge 2
            chk("prom_start", {31'h0, ~c[0]}, {31'h0, boot_prom_start});
            chk("idle", {31'h0, c[0]}, {31'h0, core_idle});
            chk("irq_en", {28'h0, {4{c[1]}}}, {28'h0, external_interrupt_en});
            chk("irq_edge", {28'h0, {4{c[1]}}}, {28'h0, external_interrupt_edge});
            chk("role", 32'h0, {31'h0, strap_role});
            chk("fault", {31'h0, c[2] | c[3]}, {31'h0, test_strap_fault});
            @(negedge core_clk);
            chk("prom_pulse", 32'h0, {31'h0, boot_prom_start});
            chk("run", {31'h0, ~c[0]}, {31'h0, core_run});
            exp_st = {c[2] | c[3], ~c[0], c[0], 1'b1, c};
            axi_read(strap_pkg::STATUS_OFFS, {24'h0, exp_st}, strap_pkg::RESP_OKAY);
            axi_read(strap_pkg::IRQ_CFG_OFFS, {24'h0, {8{c[1]}}}, strap_pkg::RESP_OKAY);
            if (c[0] && c[1]) begin
                @(posedge core_clk);
                ext_load_done <= 1'b1;
                @(posedge core_clk);
                ext_load_done <= 1'b0;
            end
            if (c[0] && !c[1]) begin
                axi_write(strap_pkg::BOOT_CTL_OFFS, 32'h0000_0001, strap_pkg::RESP_OKAY);
            end
            exp_st[6:5] = 2'b10;
            axi_read(strap_pkg::STATUS_OFFS, {24'h0, exp_st}, strap_pkg::RESP_OKAY);
        end
        axi_write(strap_pkg::IRQ_CFG_OFFS, 32'h0000_005A, strap_pkg::RESP_OKAY);
        axi_read(strap_pkg::IRQ_CFG_OFFS, 32'h0000_005A, strap_pkg::RESP_OKAY);
        // lane 0 strobe low: answered, fields untouched
        @(posedge core_clk);
        s_axi_wstrb <= 4'h0;
        axi_write(strap_pkg::IRQ_CFG_OFFS, 32'h0000_00A5, strap_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_read(strap_pkg::IRQ_CFG_OFFS, 32'h0000_005A, strap_pkg::RESP_OKAY);
        // status is read only, so the write is refused and changes nothing
        axi_write(strap_pkg::STATUS_OFFS, 32'h0000_0000, strap_pkg::RESP_SLVERR);
        axi_read(strap_pkg::STATUS_OFFS, {24'h0, exp_st}, strap_pkg::RESP_OKAY);
        axi_read(strap_pkg::BOOT_CTL_OFFS, 32'h0000_0000, strap_pkg::RESP_OKAY);
        axi_write(8'h0C, 32'h0000_00FF, strap_pkg::RESP_SLVERR);
        axi_read(8'h0C, 32'h0000_0000, strap_pkg::RESP_SLVERR);
        test_done;
    end

    // hang guard, well past the sweep length
    initial begin
        #400000;
        err_count++;
        test_done;
    end
endmodule : reset_strap_mode_capture_tb

`default_nettype wire
